//--- verilog/mode_priv_pkg.sv
package mode_priv_pkg;
	// ----------------------------------------
	// control register layout
	// ----------------------------------------
	localparam int ctrl_w = 2;
	localparam int ctrl_unpriv_bit = 0;
	localparam int ctrl_stack_sel_bit = 1;
	localparam logic [1:0] ctrl_reset = 2'h0;
	localparam int exc_num_w = 9;
	localparam logic [8:0] exc_supervisor_call = 9'h00b;
	localparam int nest_w = 8;
	localparam logic [7:0] nest_zero = 8'h00;
	localparam logic [7:0] nest_one = 8'h01;

	// ----------------------------------------
	// special register selectors
	// ----------------------------------------
	localparam logic [7:0] sreg_app_status = 8'h00;
	localparam logic [7:0] sreg_int_status = 8'h05;
	localparam logic [7:0] sreg_main_sp = 8'h08;
	localparam logic [7:0] sreg_proc_sp = 8'h09;
	localparam logic [7:0] sreg_irq_mask = 8'h10;
	localparam logic [7:0] sreg_base_pri = 8'h11;
	localparam logic [7:0] sreg_fault_mask = 8'h13;
	localparam logic [7:0] sreg_control = 8'h14;

	// ----------------------------------------
	// protected system address window
	// ----------------------------------------
	localparam logic [31:0] sys_ctrl_base = 32'he000_e000;
	localparam logic [31:0] sys_ctrl_last = 32'he000_efff;

	typedef enum logic [0:0] {
		mode_application = 1'b0,
		mode_exception = 1'b1
	} op_mode_e;
endpackage : mode_priv_pkg

//--- verilog/priv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface priv_if;
	logic privileged;
	logic exc_mode;
	logic [1:0] ctrl;
	modport producer (output privileged, output exc_mode, output ctrl);
	modport consumer (input privileged, input exc_mode, input ctrl);
endinterface : priv_if
`default_nettype wire

//--- verilog/priv_access_check.sv
`timescale 1ns/1ps
`default_nettype none
module priv_access_check (
	input wire logic clk,
	input wire logic rst,
	priv_if.consumer st,
	input wire logic sreg_read_instr_valid,
	input wire logic sreg_write_instr_valid,
	input wire logic [7:0] sreg_sel,
	input wire logic irq_mask_instr_valid,
	input wire logic bus_valid,
	input wire logic [31:0] bus_addr,
	output logic sreg_allow_q,
	output logic irq_mask_allow_q,
	output logic bus_allow_q
);
	import mode_priv_pkg::*;

	typedef struct packed {
		logic sreg_allow;
		logic irq_mask_allow;
		logic bus_allow;
	} chk_s;

	chk_s s_q;
	chk_s s_d;

	function automatic logic unpriv_sreg_ok(input logic [7:0] sel);
		unpriv_sreg_ok = (sel == sreg_app_status) || (sel == sreg_int_status)
			|| (sel == sreg_proc_sp);
	endfunction : unpriv_sreg_ok

	// ----------------------------------------
	// privilege gating
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.sreg_allow = (sreg_read_instr_valid || sreg_write_instr_valid)
			&& (st.privileged || unpriv_sreg_ok(sreg_sel));
		s_d.irq_mask_allow = irq_mask_instr_valid && st.privileged;
		s_d.bus_allow = bus_valid && (st.privileged
			|| !((bus_addr >= sys_ctrl_base) && (bus_addr <= sys_ctrl_last)));
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sreg_allow_q = s_q.sreg_allow;
	assign irq_mask_allow_q = s_q.irq_mask_allow;
	assign bus_allow_q = s_q.bus_allow;
endmodule : priv_access_check
`default_nettype wire

//--- verilog/stack_select.sv
`timescale 1ns/1ps
`default_nettype none
module stack_select (
	input wire logic clk,
	input wire logic rst,
	priv_if.consumer st,
	input wire logic instr_sync_barrier,
	output logic use_process_stack_pointer_q
);
	import mode_priv_pkg::*;

	typedef struct packed {
		logic use_psp;
	} sel_s;

	sel_s s_q;
	sel_s s_d;

	// ----------------------------------------
	// active stack choice
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		if (st.exc_mode) begin
			s_d.use_psp = 1'b0;
		end else if (instr_sync_barrier || !s_q.use_psp) begin
			s_d.use_psp = st.ctrl[ctrl_stack_sel_bit];
		end else begin
			s_d.use_psp = st.ctrl[ctrl_stack_sel_bit];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign use_process_stack_pointer_q = s_q.use_psp;
endmodule : stack_select
`default_nettype wire

//--- verilog/cpu_mode_privilege_control.sv
// Overview of operation
// - Leaving reset puts the core in application mode.
// - Every exception entry switches the core into exception mode.
// - Application mode returns only when no exception stays active or pending.
// - Unprivileged code gets a limited set of special-register moves and no irq-mask instructions.
// - Unprivileged code cannot reach the system timer, interrupt controller or system control.
// - Privileged code may use every instruction and every resource.
// - In application mode the privilege follows the control register privilege bit.
// - In exception mode execution is always privileged.
// - Control register writes from unprivileged code are ignored.
// - A supervisor call lets unprivileged code enter privileged exception code.
// - Exception mode uses the main stack pointer from its second cycle onward.
// - Exception entry and the return to application mode update the control register automatically.
// - After a barrier following a stack change the new stack pointer is in use.
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_privilege_control (
	input wire logic clk,
	input wire logic rst,
	input wire logic exc_entry,
	input wire logic [mode_priv_pkg::exc_num_w-1:0] exc_entry_num,
	input wire logic exc_return,
	input wire logic [mode_priv_pkg::ctrl_w-1:0] exc_return_ctrl,
	input wire logic exc_pending,
	input wire logic supervisor_call_instr,
	input wire logic special_reg_write_instr,
	input wire logic special_reg_read_instr,
	input wire logic [7:0] special_reg_sel,
	input wire logic [mode_priv_pkg::ctrl_w-1:0] special_reg_wdata,
	input wire logic irq_mask_set_instr,
	input wire logic irq_mask_clear_instr,
	input wire logic instr_sync_barrier,
	input wire logic bus_valid,
	input wire logic [31:0] bus_addr,
	output logic exception_mode_q,
	output logic privileged_q,
	output logic [mode_priv_pkg::ctrl_w-1:0] control_q,
	output logic [mode_priv_pkg::ctrl_w-1:0] saved_control_q,
	output logic [mode_priv_pkg::nest_w-1:0] active_count_q,
	output logic supervisor_call_req_q,
	output logic [mode_priv_pkg::exc_num_w-1:0] active_exc_num_q,
	output logic use_process_stack_pointer_q,
	output logic special_reg_allow_q,
	output logic irq_mask_allow_q,
	output logic bus_allow_q
);
	import mode_priv_pkg::*;

	typedef struct packed {
		op_mode_e mode;
		logic [ctrl_w-1:0] ctrl;
		logic [ctrl_w-1:0] saved_ctrl;
		logic [nest_w-1:0] nest;
		logic svc_req;
		logic [exc_num_w-1:0] exc_num;
	} core_s;

	core_s s_q;
	core_s s_d;
	logic priv_now;
	logic ctrl_write;

	priv_if st ();

	// ----------------------------------------
	// privilege level
	// ----------------------------------------
	always_comb begin
		if (s_q.mode == mode_exception) begin
			priv_now = 1'b1;
		end else begin
			priv_now = !s_q.ctrl[ctrl_unpriv_bit];
		end
	end

	assign ctrl_write = special_reg_write_instr && (special_reg_sel == sreg_control)
		&& priv_now;

	// ----------------------------------------
	// mode, nesting and control register
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.svc_req = 1'b0;
		if (supervisor_call_instr) begin
			s_d.svc_req = 1'b1;
		end
		if (exc_entry) begin
			s_d.mode = mode_exception;
			s_d.exc_num = exc_entry_num;
			if (s_q.nest == nest_zero) begin
				s_d.saved_ctrl = s_q.ctrl;
			end
			s_d.ctrl[ctrl_stack_sel_bit] = 1'b0;
			if (s_q.nest != {nest_w{1'b1}}) begin
				s_d.nest = s_q.nest + nest_one;
			end
		end else if (exc_return && (s_q.nest != nest_zero)) begin
			s_d.nest = s_q.nest - nest_one;
			if ((s_q.nest == nest_one) && !exc_pending) begin
				s_d.mode = mode_application;
				s_d.ctrl = exc_return_ctrl;
				s_d.exc_num = {exc_num_w{1'b0}};
			end else if (s_q.nest == nest_one) begin
				s_d.nest = s_q.nest;
			end
		end else if (ctrl_write) begin
			s_d.ctrl = special_reg_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q.mode <= mode_application;
			s_q.ctrl <= ctrl_reset;
			s_q.saved_ctrl <= ctrl_reset;
			s_q.nest <= nest_zero;
			s_q.svc_req <= 1'b0;
			s_q.exc_num <= {exc_num_w{1'b0}};
		end else begin
			s_q <= s_d;
		end
	end

	assign st.privileged = priv_now;
	assign st.exc_mode = (s_q.mode == mode_exception);
	assign st.ctrl = s_q.ctrl;

	// ----------------------------------------
	// checkers and stack selection
	// ----------------------------------------
	priv_access_check u_check (
		.clk(clk),
		.rst(rst),
		.st(st.consumer),
		.sreg_read_instr_valid(special_reg_read_instr),
		.sreg_write_instr_valid(special_reg_write_instr),
		.sreg_sel(special_reg_sel),
		.irq_mask_instr_valid(irq_mask_set_instr || irq_mask_clear_instr),
		.bus_valid(bus_valid),
		.bus_addr(bus_addr),
		.sreg_allow_q(special_reg_allow_q),
		.irq_mask_allow_q(irq_mask_allow_q),
		.bus_allow_q(bus_allow_q)
	);

	stack_select u_stack (
		.clk(clk),
		.rst(rst),
		.st(st.consumer),
		.instr_sync_barrier(instr_sync_barrier),
		.use_process_stack_pointer_q(use_process_stack_pointer_q)
	);

	assign exception_mode_q = (s_q.mode == mode_exception);
	assign control_q = s_q.ctrl;
	assign saved_control_q = s_q.saved_ctrl;
	assign active_count_q = s_q.nest;
	assign supervisor_call_req_q = s_q.svc_req;
	assign active_exc_num_q = s_q.exc_num;

	// privileged_q registered separately to stay a flop output
	logic priv_reg_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			priv_reg_q <= 1'b1;
		end else begin
			priv_reg_q <= (s_d.mode == mode_exception) || !s_d.ctrl[ctrl_unpriv_bit];
		end
	end
	assign privileged_q = priv_reg_q;
endmodule : cpu_mode_privilege_control
`default_nettype wire

//--- dv/cpu_mode_privilege_control_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_privilege_control_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic exc_entry,
	input wire logic exc_return,
	input wire logic [mode_priv_pkg::ctrl_w-1:0] exc_return_ctrl,
	input wire logic exc_pending,
	input wire logic irq_mask_set_instr,
	input wire logic irq_mask_clear_instr,
	input wire logic bus_valid,
	input wire logic [31:0] bus_addr,
	input wire logic exception_mode_q,
	input wire logic privileged_q,
	input wire logic [mode_priv_pkg::ctrl_w-1:0] control_q,
	input wire logic [mode_priv_pkg::nest_w-1:0] active_count_q,
	input wire logic use_process_stack_pointer_q,
	input wire logic irq_mask_allow_q,
	input wire logic bus_allow_q
);
	import mode_priv_pkg::*;
	// ----------------------------------------
	// mode and privilege checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	reset_app_a: assert property (disable iff (1'b0)
		rst |=> !exception_mode_q && privileged_q && control_q == ctrl_reset)
		else $error("reset state wrong");
	entry_mode_a: assert property (
		exc_entry |=> exception_mode_q && privileged_q && !control_q[ctrl_stack_sel_bit])
		else $error("entry state wrong");
	final_return_a: assert property (
		exc_return && !exc_entry && !exc_pending && active_count_q == nest_one
		|=> !exception_mode_q && control_q == $past(exc_return_ctrl))
		else $error("final return wrong");
	pending_hold_a: assert property (
		exc_return && !exc_entry && exc_pending && active_count_q == nest_one
		|=> exception_mode_q && active_count_q == nest_one)
		else $error("return with pending left mode");
	priv_level_a: assert property (
		privileged_q == (exception_mode_q || !control_q[ctrl_unpriv_bit]))
		else $error("privilege level wrong");
	unpriv_write_a: assert property (
		!privileged_q && !exc_entry && !exc_return |=> $stable(control_q))
		else $error("unprivileged control change");
	irq_block_a: assert property (
		irq_mask_set_instr || irq_mask_clear_instr |=> irq_mask_allow_q == $past(privileged_q))
		else $error("irq mask allow wrong");
	sys_block_a: assert property (
		bus_valid && !privileged_q && bus_addr inside {[sys_ctrl_base:sys_ctrl_last]}
		|=> !bus_allow_q) else $error("system access allowed");
	stack_sel_a: assert property (
		!exception_mode_q && control_q[ctrl_stack_sel_bit] |=> use_process_stack_pointer_q)
		else $error("process stack not selected");
endmodule : cpu_mode_privilege_control_checker
bind cpu_mode_privilege_control cpu_mode_privilege_control_checker checker_inst (.*);
`default_nettype wire

//--- dv/test_cpu_mode_privilege_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_mode_privilege_control;
	import mode_priv_pkg::*;
	logic clk, rst, exc_entry, exc_return, exc_pending, supervisor_call_instr, bus_valid;
	logic special_reg_write_instr, special_reg_read_instr, instr_sync_barrier, m, p, process_stack_pointer;
	logic irq_mask_set_instr, irq_mask_clear_instr, exception_mode_q, privileged_q;
	logic supervisor_call_req_q, use_process_stack_pointer_q, special_reg_allow_q;
	logic irq_mask_allow_q, bus_allow_q;
	logic [8:0] exc_entry_num, active_exc_num_q, num;
	logic [1:0] exc_return_ctrl, special_reg_wdata, control_q, saved_control_q, ctrl, saved;
	logic [7:0] special_reg_sel, active_count_q;
	logic [31:0] bus_addr;
	logic [3:0] alw;
	logic [7:0] sels [8] = '{sreg_app_status, sreg_int_status, sreg_main_sp, sreg_proc_sp,
		sreg_irq_mask, sreg_base_pri, sreg_fault_mask, sreg_control};
	integer seed = 6452;
	int num_errors = 0;
	int comparisons = 0;
	int depth;
	cpu_mode_privilege_control cpu_mode_privilege_control_inst (.*);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic do_reset;
		rst = 1'b1;
		{exc_entry, exc_return, exc_pending, supervisor_call_instr, bus_valid, bus_addr,
			special_reg_write_instr, special_reg_read_instr, instr_sync_barrier, exc_entry_num,
			irq_mask_set_instr, irq_mask_clear_instr, exc_return_ctrl, special_reg_wdata,
			special_reg_sel} = '0;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		{m, process_stack_pointer, ctrl, saved, alw, num} = '0;
		depth = 0;
	endtask : do_reset
	task automatic final_report;
		$display("num_errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	// ----------------------------------------
	// random stimulus against the model
	// ----------------------------------------
	initial begin
		do_reset();
		for (int i = 1; i < 3000; i++) begin
			@(negedge clk);
			if (i % 1000 == 0) do_reset();
			chk("mode", 9'(m), 9'(exception_mode_q));
			chk("priv", 9'(m | !ctrl[0]), 9'(privileged_q));
			chk("exc_num", num, active_exc_num_q);
			chk("control", 9'(ctrl), 9'(control_q));
			chk("saved", 9'(saved), 9'(saved_control_q));
			chk("depth", 9'(depth), 9'(active_count_q));
			chk("stack", 9'(process_stack_pointer), 9'(use_process_stack_pointer_q));
			chk("allow", 9'(alw), 9'({special_reg_allow_q, irq_mask_allow_q,
				bus_allow_q, supervisor_call_req_q}));
			exc_entry = supervisor_call_req_q | (($random(seed) & 15) == 0);
			exc_entry_num = supervisor_call_req_q ? exc_supervisor_call : 9'($random(seed));
			exc_return = !exc_entry && (($random(seed) & 7) == 0);
			exc_return_ctrl = 2'($random(seed));
			exc_pending = ($random(seed) & 3) == 0;
			supervisor_call_instr = ($random(seed) & 15) == 0;
			special_reg_write_instr = !exc_entry && !exc_return && (($random(seed) & 3) == 0);
			special_reg_read_instr = ($random(seed) & 3) == 0;
			special_reg_sel = sels[$random(seed) & 7];
			special_reg_wdata = 2'($random(seed));
			instr_sync_barrier = 1'($random(seed));
			irq_mask_set_instr = ($random(seed) & 7) == 0;
			irq_mask_clear_instr = ($random(seed) & 7) == 0;
			bus_valid = 1'($random(seed));
			bus_addr = 32'he000_d000 + (32'($random(seed)) & 32'h0000_3fff);
			p = m | ~ctrl[0];
			alw[3] = (special_reg_read_instr | special_reg_write_instr)
				& (p | special_reg_sel inside {sreg_app_status, sreg_int_status, sreg_proc_sp});
			alw[2] = (irq_mask_set_instr | irq_mask_clear_instr) & p;
			alw[1] = bus_valid & (p | !(bus_addr inside {[sys_ctrl_base:sys_ctrl_last]}));
			alw[0] = supervisor_call_instr;
			process_stack_pointer = ~m & ctrl[1];
			if (exc_entry) begin
				if (depth == 0) saved = ctrl;
				if (depth < 255) depth++;
				num = exc_entry_num;
				m = 1'b1;
				ctrl[1] = 1'b0;
			end else if (exc_return && depth > 1) begin
				depth--;
			end else if (exc_return && depth == 1 && !exc_pending) begin
				depth = 0;
				m = 1'b0;
				num = '0;
				ctrl = exc_return_ctrl;
			end else if (special_reg_write_instr && special_reg_sel == sreg_control && p) begin
				ctrl = special_reg_wdata;
			end
		end
		final_report();
	end
endmodule : test_cpu_mode_privilege_control
`default_nettype wire
